// ==== hbag_pkg.sv ====
// Purpose: constants and types for the host bus arbiter glue
// Assumes: AXI4-Lite register access, one 25 MHz clock
// Notes:   register offsets are byte addresses, one word each
package hbag_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W           = 6;
  localparam logic [5:0]  ADDR_BANK0_BASE  = 6'h00;
  localparam logic [5:0]  ADDR_BANK_OPT    = 6'h04;
  localparam logic [5:0]  ADDR_HOST_CFG    = 6'h08;
  localparam logic [5:0]  ADDR_CTRL        = 6'h0C;
  localparam logic [5:0]  ADDR_STATUS      = 6'h10;
  localparam logic [5:0]  ADDR_STRAPS      = 6'h14;
  localparam logic [31:0] BANK0_BASE_RST   = 32'h0000_0000;
  localparam logic [31:0] BANK_OPT_RST     = 32'h0000_0000;
  localparam logic [31:0] HOST_CFG_RST     = 32'h0000_0000;
  // ****************************************************************
  // field layout and expected host values
  // ****************************************************************
  localparam int          BASE_VALID_BIT   = 0;
  localparam int          BASE_FIELD_LSB   = 11;
  localparam logic [20:0] BASE_EXPECT      = 21'h01_2000;
  localparam int          OPT_DRAM_BIT     = 10;
  localparam int          OPT_PSIZE_LSB    = 1;
  localparam logic [1:0]  PSIZE_EXT_ACK    = 2'h3;
  localparam int          OPT_MASK_LSB     = 11;
  localparam logic [16:0] MASK_ALL         = 17'h1_FFFF;
  localparam int          OPT_CYCLE_LSB    = 28;
  localparam logic [3:0]  CYCLE_EXPECT     = 4'hF;
  localparam int          HCFG_BUS_TM_BIT  = 0;
  localparam int          HCFG_ARB_TM_BIT  = 1;
  localparam int          HCFG_PE_LSB      = 16;
  localparam int          PE_AUTO_VECTOR_INPUT_BIT      = 0;
  localparam int          PE_STROBE_BIT    = 7;
  localparam int          PE_PINFN_LSB     = 8;
  localparam logic [1:0]  PINFN_CONFIG     = 2'h0;
  localparam int          CTRL_ARB_EN_BIT  = 0;
  localparam int          CTRL_RECAP_BIT   = 1;
  // strap index within the latched strap vector and on the data pins
  localparam int          STRAP_RW_POLARITY_STRAP      = 0;
  localparam int          STRAP_HOST_MODE_STRAP       = 1;
  localparam int          STRAP_ARB_OFF    = 2;
  localparam int          STRAP_LITTLE_ENDIAN_STRAP       = 3;
  localparam logic [1:0]  STRAP_SETTLE     = 2'h3;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  typedef enum logic [1:0] {WR_IDLE = 2'h0, WR_RESP = 2'h1} hbag_wr_state_type;
  typedef enum logic       {RD_IDLE = 1'h0, RD_DATA = 1'h1} hbag_rd_state_type;
endpackage

// ==== hbag_sync.sv ====
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs change slowly against clk
// Notes:   only stage two leaves this module
`timescale 1ns/10ps
module hbag_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // pins in, synchronised out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hbag_sync_st_type;
  hbag_sync_st_type st_q;
  hbag_sync_st_type st_d;
  // a zero-width synchroniser is refused at elaboration
  if (W < 1) begin : g_bad_width
    $error("hbag_sync width must be positive");
  end
  // stage one feeds stage two only
  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign sync_out = st_q.s2;
endmodule // hbag_sync

// ==== hbag_arb_core.sv ====
// Purpose: grant latch and hold acknowledge of the external arbiter
// Assumes: step pulses once per rising expansion clock edge
// Notes:   disabled core releases request at once and busy enable on the next clk
`timescale 1ns/10ps
module hbag_arb_core import hbag_pkg::*; (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // expansion clock edge and level
  input  wire logic step,
  input  wire logic xclk_high,
  // arbitration inputs, synchronised
  input  wire logic enable,
  input  wire logic hold_request,
  input  wire logic bus_grant_in_n,
  // arbitration outputs
  output logic      grant_latched,
  output logic      hold_acknowledge,
  output logic      bus_request_out_n,
  output logic      bus_busy_out_n,
  output logic      bus_busy_oe
);
  typedef struct packed {
    logic grant;
    logic hold_ack;
  } hbag_arb_st_type;
  hbag_arb_st_type st_q;
  hbag_arb_st_type st_d;
  // both flops advance only on the expansion clock edge, and clear on the next clk whenever disabled
  always_comb begin
    st_d = st_q;
    if (!enable) begin
      st_d = '0;
    end else if (step) begin
      st_d.grant    = !bus_grant_in_n || (st_q.grant && hold_request);
      st_d.hold_ack = (st_q.grant && xclk_high) || (st_q.hold_ack && hold_request);
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign grant_latched     = st_q.grant;
  assign hold_acknowledge  = st_q.hold_ack;
  assign bus_request_out_n = !(enable && hold_request && !st_q.hold_ack);
  assign bus_busy_out_n    = 1'b0;
  assign bus_busy_oe       = st_q.hold_ack;
endmodule // hbag_arb_core

// ==== hbag_glue.sv ====
// Purpose: host bus arbiter glue with strap latch and register file
// Assumes: AXI4-Lite slave, pins synchronised to clk
// Notes:   host setting registers mirror what the host must program
`timescale 1ns/10ps
module hbag_glue import hbag_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // axi4-lite write address
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // expansion bus arbitration pins
  input  wire logic        expansion_clock,
  input  wire logic        hold_request,
  output logic             hold_acknowledge,
  // host arbitration pins
  input  wire logic        bus_grant_in_n,
  output logic             bus_request_out_n,
  input  wire logic        bus_busy_in_n,
  output logic             bus_busy_out_n,
  output logic             bus_busy_oe,
  // boot straps on the data bus
  input  wire logic [3:0]  strap_pins,
  // latched boot configuration
  output logic             write_strobe_active_low,
  output logic             async_slave_mode,
  output logic             internal_arbiter_off,
  output logic             little_endian
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    hbag_wr_state_type wst;
    hbag_rd_state_type rst;
    logic              aw_got;
    logic              w_got;
    logic [5:0]        waddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [31:0]       bank0_base;
    logic [31:0]       bank_opt;
    logic [31:0]       host_cfg;
    logic              arb_en;
    logic [3:0]        straps;
    logic              strap_ok;
    logic [1:0]        settle;
    logic              xclk_prev;
  } hbag_glue_st_type;
  hbag_glue_st_type st_q;
  hbag_glue_st_type st_d;

  logic [7:0]  pin_sync;
  logic        xclk_s;
  logic        hold_s;
  logic        grant_n_s;
  logic        busy_n_s;
  logic [3:0]  strap_s;
  logic        xclk_rise;
  logic        arb_enable;
  logic        grant_latched;
  logic        cfg_ok;
  logic [31:0] status_word;
  logic        wr_fire;
  logic [5:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // every pin input crosses two flops before any logic sees it
  hbag_sync #(
    .W (8)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pin_in   ({strap_pins, bus_busy_in_n, bus_grant_in_n,
                hold_request, expansion_clock}),
    .sync_out (pin_sync)
  );
  assign xclk_s    = pin_sync[0];
  assign hold_s    = pin_sync[1];
  assign grant_n_s = pin_sync[2];
  assign busy_n_s  = pin_sync[3];
  assign strap_s   = pin_sync[7:4];

  // expansion clock rise becomes a one-cycle step enable
  assign xclk_rise = xclk_s && !st_q.xclk_prev;

  // ****************************************************************
  // arbiter
  // ****************************************************************
  // external arbiter only when strap says so
  assign arb_enable = st_q.strap_ok && st_q.straps[STRAP_ARB_OFF] && st_q.arb_en;

  hbag_arb_core u_arb (
    .clk               (clk),
    .reset_n           (reset_n),
    .step              (xclk_rise),
    .xclk_high         (xclk_s),
    .enable            (arb_enable),
    .hold_request      (hold_s),
    .bus_grant_in_n    (grant_n_s),
    .grant_latched     (grant_latched),
    .hold_acknowledge  (hold_acknowledge),
    .bus_request_out_n (bus_request_out_n),
    .bus_busy_out_n    (bus_busy_out_n),
    .bus_busy_oe       (bus_busy_oe)
  );

  // ****************************************************************
  // host setting check
  // ****************************************************************
  // one bit tells software the host mirror is fit for the link
  always_comb begin
    cfg_ok = 1'b1;
    if (!st_q.bank0_base[BASE_VALID_BIT]) cfg_ok = 1'b0;
    if (st_q.bank0_base[BASE_FIELD_LSB +: 21] != BASE_EXPECT) cfg_ok = 1'b0;
    if (st_q.bank_opt[OPT_DRAM_BIT]) cfg_ok = 1'b0;
    if (st_q.bank_opt[OPT_PSIZE_LSB +: 2] != PSIZE_EXT_ACK) cfg_ok = 1'b0;
    if (st_q.bank_opt[OPT_MASK_LSB +: 17] != MASK_ALL) cfg_ok = 1'b0;
    if (st_q.bank_opt[OPT_CYCLE_LSB +: 4] != CYCLE_EXPECT) cfg_ok = 1'b0;
    if (st_q.host_cfg[HCFG_BUS_TM_BIT]) cfg_ok = 1'b0;
    if (st_q.host_cfg[HCFG_ARB_TM_BIT]) cfg_ok = 1'b0;
    if (st_q.host_cfg[HCFG_PE_LSB + PE_PINFN_LSB +: 2] != PINFN_CONFIG) cfg_ok = 1'b0;
    if (!st_q.host_cfg[HCFG_PE_LSB + PE_STROBE_BIT]) cfg_ok = 1'b0;
    if (st_q.host_cfg[HCFG_PE_LSB + PE_AUTO_VECTOR_INPUT_BIT]) cfg_ok = 1'b0;
  end

  assign status_word = {22'h0,
                        !st_q.straps[STRAP_HOST_MODE_STRAP] && st_q.strap_ok,
                        st_q.strap_ok,
                        cfg_ok,
                        arb_enable,
                        !busy_n_s,
                        !grant_n_s,
                        hold_s,
                        hold_acknowledge,
                        grant_latched,
                        1'b0};

  // ****************************************************************
  // write channel alignment
  // ****************************************************************
  // address and data may arrive in either order or together
  assign wr_addr = st_q.aw_got ? st_q.waddr : s_axi_awaddr;
  assign wr_data = st_q.w_got  ? st_q.wdata : s_axi_wdata;
  assign wr_strb = st_q.w_got  ? st_q.wstrb : s_axi_wstrb;
  assign wr_fire = (st_q.wst == WR_IDLE) &&
                   (st_q.aw_got || s_axi_awvalid) &&
                   (st_q.w_got  || s_axi_wvalid);

  // byte lanes outside the strobe keep their old value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_d           = st_q;
    st_d.xclk_prev = xclk_s;

    // strap catch after the synchroniser has filled
    // latch of all four boot straps
    if (!st_q.strap_ok) begin
      if (st_q.settle == STRAP_SETTLE) begin
        st_d.straps   = strap_s;
        st_d.strap_ok = 1'b1;
      end else begin
        st_d.settle = st_q.settle + 2'h1;
      end
    end

    // write path
    case (st_q.wst)
      WR_IDLE: begin
        if (wr_fire) begin
          st_d.aw_got = 1'b0;
          st_d.w_got  = 1'b0;
          st_d.bresp  = RESP_OKAY;
          st_d.wst    = WR_RESP;
          if (wr_addr == ADDR_BANK0_BASE) begin
            st_d.bank0_base = merge(st_q.bank0_base, wr_data, wr_strb);
          end else if (wr_addr == ADDR_BANK_OPT) begin
            st_d.bank_opt = merge(st_q.bank_opt, wr_data, wr_strb);
          end else if (wr_addr == ADDR_HOST_CFG) begin
            st_d.host_cfg = merge(st_q.host_cfg, wr_data, wr_strb);
          end else if (wr_addr == ADDR_CTRL) begin
            if (wr_strb[0]) begin
              st_d.arb_en = wr_data[CTRL_ARB_EN_BIT];
              // recapture restarts the strap settle count
              if (wr_data[CTRL_RECAP_BIT]) begin
                st_d.strap_ok = 1'b0;
                st_d.settle   = 2'h0;
              end
            end
          end else if (wr_addr == ADDR_STATUS || wr_addr == ADDR_STRAPS) begin
            st_d.bresp = RESP_OKAY;
          end else begin
            st_d.bresp = RESP_SLVERR;
          end
        end else begin
          if (s_axi_awvalid && !st_q.aw_got) begin
            st_d.aw_got = 1'b1;
            st_d.waddr  = s_axi_awaddr;
          end
          if (s_axi_wvalid && !st_q.w_got) begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) st_d.wst = WR_IDLE;
      end
      default: st_d.wst = WR_IDLE;
    endcase

    // read path
    case (st_q.rst)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          st_d.rst   = RD_DATA;
          st_d.rresp = RESP_OKAY;
          if (s_axi_araddr == ADDR_BANK0_BASE) begin
            st_d.rdata = st_q.bank0_base;
          end else if (s_axi_araddr == ADDR_BANK_OPT) begin
            st_d.rdata = st_q.bank_opt;
          end else if (s_axi_araddr == ADDR_HOST_CFG) begin
            st_d.rdata = st_q.host_cfg;
          end else if (s_axi_araddr == ADDR_CTRL) begin
            st_d.rdata = {31'h0, st_q.arb_en};
          end else if (s_axi_araddr == ADDR_STATUS) begin
            st_d.rdata = status_word;
          end else if (s_axi_araddr == ADDR_STRAPS) begin
            st_d.rdata = {28'h0, st_q.straps};
          end else begin
            st_d.rdata = 32'h0000_0000;
            st_d.rresp = RESP_SLVERR;
          end
        end
      end
      RD_DATA: begin
        if (s_axi_rready) st_d.rst = RD_IDLE;
      end
      default: st_d.rst = RD_IDLE;
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q            <= '0;
      st_q.wst        <= WR_IDLE;
      st_q.rst        <= RD_IDLE;
      st_q.bank0_base <= BANK0_BASE_RST;
      st_q.bank_opt   <= BANK_OPT_RST;
      st_q.host_cfg   <= HOST_CFG_RST;
      st_q.arb_en     <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // handshakes are decoded from state, data from flops
  assign s_axi_awready = (st_q.wst == WR_IDLE) && !st_q.aw_got;
  assign s_axi_wready  = (st_q.wst == WR_IDLE) && !st_q.w_got;
  assign s_axi_bvalid  = (st_q.wst == WR_RESP);
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = (st_q.rst == RD_IDLE);
  assign s_axi_rvalid  = (st_q.rst == RD_DATA);
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;

  // boot configuration shows zero from reset until the straps are caught; a recapture zeroes only async_slave_mode
  // active-low write select
  assign write_strobe_active_low = st_q.straps[STRAP_RW_POLARITY_STRAP];
  assign async_slave_mode        = st_q.strap_ok && !st_q.straps[STRAP_HOST_MODE_STRAP];
  assign internal_arbiter_off    = st_q.straps[STRAP_ARB_OFF];
  assign little_endian           = st_q.straps[STRAP_LITTLE_ENDIAN_STRAP];
endmodule // hbag_glue

// ==== hbag_glue_chk.sv ====
// Purpose: port-level checks of the arbiter glue
// Assumes: bound to hbag_glue, single clk domain
// Notes:   expansion clock pin runs far slower than clk
`timescale 1ns/10ps
module hbag_glue_chk import hbag_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // arbitration and status ports
  input wire logic hold_request,
  input wire logic hold_acknowledge,
  input wire logic bus_grant_in_n,
  input wire logic bus_request_out_n,
  input wire logic bus_busy_out_n,
  input wire logic bus_busy_oe,
  input wire logic internal_arbiter_off,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready
);
  // ********************************
  // arbitration properties
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [5:0] grant_age_q;
  logic [5:0] grant_age_d;
  // age of the last grant, saturating so it never wraps back to young
  always_comb grant_age_d = !bus_grant_in_n ? 6'h00 :
                            (grant_age_q == 6'h3F) ? grant_age_q : grant_age_q + 6'h01;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) grant_age_q <= 6'h3F;
    else grant_age_q <= grant_age_d;
  end
  chk_ack_blocks_req: assert property (
    hold_acknowledge |-> bus_request_out_n) else $error("request while acknowledged");
  chk_idle_no_req: assert property (
    !hold_request [*4] |-> bus_request_out_n) else $error("request without hold");
  chk_busy_follows_ack: assert property (
    bus_busy_oe == hold_acknowledge) else $error("busy enable not tied to acknowledge");
  chk_busy_drives_low: assert property (
    bus_busy_oe |-> !bus_busy_out_n) else $error("busy driven high");
  chk_reset_clears: assert property (
    $rose(reset_n) |-> !hold_acknowledge && bus_request_out_n && !bus_busy_oe)
    else $error("arbiter not clear after reset");
  chk_ack_drops: assert property (
    $fell(hold_request) |-> ##[1:24] !hold_acknowledge) else $error("acknowledge stuck");
  chk_ack_after_grant: assert property (
    $rose(hold_acknowledge) |-> grant_age_q < 6'h28) else $error("acknowledge without grant");
  chk_ack_arb_off: assert property (
    $rose(hold_acknowledge) |-> internal_arbiter_off) else $error("acknowledge with arbiter on");
  cover property ($rose(hold_acknowledge));
  cover property ($fell(bus_request_out_n));
  cover property (s_axi_awvalid && s_axi_awready);
endmodule // hbag_glue_chk

bind hbag_glue hbag_glue_chk hbag_glue_chk_i (.clk, .reset_n, .hold_request, .hold_acknowledge,
  .bus_grant_in_n, .bus_request_out_n, .bus_busy_out_n, .bus_busy_oe, .internal_arbiter_off,
  .s_axi_awvalid, .s_axi_awready);

// ==== hbag_host_model.sv ====
// Purpose: host side of bus arbitration, grants on request
// Assumes: busy wire has a pull-up on the board
// Notes:   grant_delay paces a prompt or a slow host
`timescale 1ns/10ps
module hbag_host_model (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // pacing and arbitration wires
  input wire logic [3:0] grant_delay,
  input wire logic       bus_request_out_n,
  input wire logic       bus_busy_out_n,
  input wire logic       bus_busy_oe,
  output logic           bus_grant_in_n,
  output logic           bus_busy_in_n
);
  logic [3:0] wait_q;
  // released busy line floats to the pull-up level
  assign bus_busy_in_n = bus_busy_oe ? bus_busy_out_n : 1'b1;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= 4'h0;
      bus_grant_in_n <= 1'b1;
    end else if (!bus_busy_in_n || (bus_request_out_n && bus_grant_in_n)) begin
      wait_q <= 4'h0;
      bus_grant_in_n <= 1'b1;
    end else if (wait_q >= grant_delay) bus_grant_in_n <= 1'b0;
    else wait_q <= wait_q + 4'h1;
  end
endmodule // hbag_host_model

// ==== hbag_glue_tb.sv ====
// Purpose: register and arbitration tests of the glue
// Assumes: host model grants on request, straps held on pins
// Notes:   readies sampled at the falling edge, driven after rising
`timescale 1ns/10ps
module hbag_glue_tb;
  import hbag_pkg::*;
  // ********************************
  // signals and instances
  // ********************************
  logic clk = 1'b0, reset_n = 1'b0, expansion_clock = 1'b0, hold_request = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic bus_grant_in_n, bus_request_out_n, bus_busy_in_n, bus_busy_out_n, bus_busy_oe;
  logic hold_acknowledge, write_strobe_active_low, async_slave_mode;
  logic internal_arbiter_off, little_endian;
  logic [3:0] strap_pins = 4'hD, grant_delay = 4'h0;
  int miscompares = 0, n_compared = 0;
  logic [5:0] bad_a [11] = '{6'h00, 6'h00, 6'h04, 6'h04, 6'h04, 6'h04,
                             6'h08, 6'h08, 6'h08, 6'h08, 6'h08};
  logic [31:0] bad_v [11] = '{32'h0900_0000, 32'h0900_0801, 32'hFFFF_FC06, 32'hFFFF_F802,
    32'hFFFF_F006, 32'h0FFF_F806, 32'h0080_0001, 32'h0080_0002, 32'h0180_0000,
    32'h0000_0000, 32'h0081_0000};
  hbag_glue hbag_glue_i (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .expansion_clock,
    .hold_request, .hold_acknowledge, .bus_grant_in_n, .bus_request_out_n, .bus_busy_in_n,
    .bus_busy_out_n, .bus_busy_oe, .strap_pins, .write_strobe_active_low,
    .async_slave_mode, .internal_arbiter_off, .little_endian);
  hbag_host_model hbag_host_model_i (.clk, .reset_n, .grant_delay, .bus_request_out_n,
    .bus_busy_out_n, .bus_busy_oe, .bus_grant_in_n, .bus_busy_in_n);
  // clk at 40 ns; expansion clock on an unrelated period
  always #20 clk = ~clk;
  always #113 expansion_clock = ~expansion_clock;
  // ********************************
  // tasks
  // ********************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_write(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, done;
    int n;
    done = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && n < 40) begin
      @(negedge clk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid === 1'b1;
      if (done) cmp({30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge clk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    cmp({31'h0, done}, 32'h1);
    @(posedge clk);
  endtask
  task automatic axi_check(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
                           input logic [1:0] er);
    logic ar_t, done;
    int n;
    done = 1'b0;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < 40) begin
      @(negedge clk);
      ar_t = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid === 1'b1;
      if (done) cmp(s_axi_rdata & m, e);
      if (done) cmp({30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge clk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    cmp({31'h0, done}, 32'h1);
    @(posedge clk);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ********************************
  // test sequence
  // ********************************
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    axi_check(ADDR_BANK0_BASE, 32'hFFFF_FFFF, BANK0_BASE_RST, RESP_OKAY);
    axi_check(ADDR_BANK_OPT, 32'hFFFF_FFFF, BANK_OPT_RST, RESP_OKAY);
    axi_check(ADDR_HOST_CFG, 32'hFFFF_FFFF, HOST_CFG_RST, RESP_OKAY);
    axi_check(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0001, RESP_OKAY);
    axi_check(6'h18, 32'hFFFF_FFFF, 32'h0000_0000, RESP_SLVERR);
    axi_write(6'h18, 32'h1234_5678, RESP_SLVERR);
    axi_write(ADDR_STRAPS, 32'h0000_0000, RESP_OKAY);
    axi_check(ADDR_STRAPS, 32'hFFFF_FFFF, 32'h0000_000D, RESP_OKAY);
    cmp({write_strobe_active_low, async_slave_mode, internal_arbiter_off, little_endian},
        32'hF);
    axi_write(ADDR_BANK0_BASE, 32'h0900_0001, RESP_OKAY);
    axi_write(ADDR_BANK_OPT, 32'hFFFF_F806, RESP_OKAY);
    axi_write(ADDR_HOST_CFG, 32'h0080_0000, RESP_OKAY);
    axi_check(ADDR_BANK_OPT, 32'hFFFF_FFFF, 32'hFFFF_F806, RESP_OKAY);
    axi_check(ADDR_STATUS, 32'h0000_03C0, 32'h0000_03C0, RESP_OKAY);
    // each wrong host setting must clear the settings-ok status bit
    for (int i = 0; i < 11; i++) begin
      axi_write(bad_a[i], bad_v[i], RESP_OKAY);
      axi_check(ADDR_STATUS, 32'h80, 32'h0, RESP_OKAY);
      axi_write(bad_a[i], (bad_a[i] == 6'h00) ? 32'h0900_0001 :
                (bad_a[i] == 6'h04) ? 32'hFFFF_F806 : 32'h0080_0000, RESP_OKAY);
    end
    axi_check(ADDR_STATUS, 32'h80, 32'h80, RESP_OKAY);
    // hold cycles with a prompt and then a slow host
    for (int k = 0; k < 2; k++) begin
      grant_delay <= (k == 0) ? 4'h0 : 4'hA;
      hold_request <= 1'b1;
      repeat (20) if (bus_request_out_n !== 1'b0) @(negedge clk);
      cmp({31'h0, bus_request_out_n}, 32'h0);
      repeat (80) if (hold_acknowledge !== 1'b1) @(negedge clk);
      // let the released grant pass the pin synchroniser
      repeat (4) @(posedge clk);
      axi_check(ADDR_STATUS, 32'h3E, 32'h2E, RESP_OKAY);
      cmp({bus_request_out_n, hold_acknowledge, bus_busy_oe, bus_busy_in_n}, 32'hE);
      hold_request <= 1'b0;
      repeat (40) if (hold_acknowledge !== 1'b0) @(negedge clk);
      cmp({bus_request_out_n, hold_acknowledge, bus_busy_oe, bus_busy_in_n}, 32'h9);
      @(posedge clk);
    end
    // a cleared enable bit parks the arbiter whatever the straps say
    axi_write(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    axi_check(ADDR_STATUS, 32'h40, 32'h0, RESP_OKAY);
    // recapture straps with the internal arbiter left on
    strap_pins <= 4'h2;
    axi_write(ADDR_CTRL, 32'h0000_0003, RESP_OKAY);
    repeat (8) @(posedge clk);
    hold_request <= 1'b1;
    repeat (20) @(posedge clk);
    cmp({bus_request_out_n, write_strobe_active_low, async_slave_mode, internal_arbiter_off,
         little_endian}, 32'h10);
    axi_check(ADDR_STRAPS, 32'hF, 32'h2, RESP_OKAY);
    end_of_test();
  end
  // watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #400000;
    miscompares++;
    end_of_test();
  end
endmodule // hbag_glue_tb
